// [shared/usc_consts.vh]
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
// Register byte offsets
`define USC_OFF_STATUS 8'h00
`define USC_OFF_CLKSEL 8'h04
`define USC_OFF_CMD 8'h08
`define USC_OFF_TXBUF 8'h0C
`define USC_OFF_RXBUF 8'h10
`define USC_OFF_IPCR 8'h14
`define USC_OFF_MODE1 8'h18
`define USC_OFF_ISR 8'h1C
`define USC_OFF_IMR 8'h20
`define USC_OFF_ICLR 8'h24
`define USC_OFF_DIV 8'h28
// Status bits
`define USC_ST_RX_READY_FLAG 0
`define USC_ST_RX_FIFO_FULL_FLAG 1
`define USC_ST_TX_READY_FLAG 2
`define USC_ST_TXEMP 3
`define USC_ST_RXEN 4
`define USC_ST_TXEN 5
// Interrupt status / mask bits
`define USC_IS_TX_READY_FLAG 0
`define USC_IS_RX 1
`define USC_IS_DBRK 2
`define USC_IS_COS 7
// Mode register one
`define USC_MR1_RXSEL 6
// Command bits
`define USC_CMD_RXEN 0
`define USC_CMD_RXDIS 1
`define USC_CMD_TXEN 2
`define USC_CMD_TXDIS 3
`define USC_CMD_RXRST 4
`define USC_CMD_TXRST 5
// Input port change bits
`define USC_IP_CTS 0
`define USC_IP_COS 4
// Clock select fields and codes
`define USC_CS_RX_HI 7
`define USC_CS_RX_LO 4
`define USC_CS_TX_HI 3
`define USC_CS_TX_LO 0
`define USC_CS_INT 4'hD
`define USC_CS_TIM16 4'hE
`define USC_CS_TIM 4'hF
`define USC_CS_RESET 8'hDD
// Misc reset values and counts
`define USC_DIV_RESET 16'h0001
`define USC_TICK_LAST 4'hF
`define USC_TICK_MID 4'h7
`define USC_BIT_STOP 4'h9
`define USC_RESP_OK 2'b00
`define USC_RESP_ERR 2'b10
`endif

// [rtl/usc_uart.v]
/*
 Serial receiver/transmitter with receive FIFO, transmit holding and shift
 registers, per-direction clock source selection, interrupt and DMA requests,
 all registers reached over an AXI4-Lite slave.
 Assumes one clock aclk, synchronous active-low aresetn; rxd, cts_n and
 timer_clock_input are asynchronous pins.
*/
// Overview of operation
// - The receive-FIFO-full flag sets when a character fills the FIFO, and characters arriving while full are lost.
// - The receiver-ready flag in status bit 0 is high while any character waits and clears when none remain.
// - Clock select bits 7-4 pick the receiver source and 3-0 the transmitter: D internal, E timer/16, F timer.
// - Both directions are clocked independently, and the value DD, also the reset value, puts both on internal.
// - The holding register takes a character only while transmitter-ready is set, and the write clears that flag.
// - An empty shifter of an enabled transmitter loads a valid held character and sets transmitter-ready again.
// - A transmit write while not ready and disabled leaves the buffer untouched.
// - The input port change register reports the clear-to-send level and whether it changed.
// - Mask bits 7 change of state, 2 delta break, 1 receive (FIFO full or receiver ready), 0 transmitter ready; mode one bit 6 picks the receive source.
// - The transmit DMA request is high whenever transmitter-ready is set in interrupt status.
// - The receive DMA request is high whenever the selected FIFO-full or receiver-ready flag is set.
// - Change of state and delta break still raise interrupts while DMA moves the data.
`timescale 1ns/1ps
`include "usc_consts.vh"

module usc_uart #(
  parameter RX_DEPTH = 3,
  parameter RX_CW = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rxd,
  output reg txd,
  input wire clear_to_send_input_n,
  input wire timer_clock_input,
  output wire irq,
  output wire tx_dma_req,
  output wire rx_dma_req
);

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `USC_OFF_DIV) && (a[1:0] == 2'b00);
    end
  endfunction

  function tick_sel;
    input [3:0] cs;
    input t_int;
    input t_16;
    input t_1;
    begin
      case (cs)
        `USC_CS_TIM16: tick_sel = t_16;
        `USC_CS_TIM: tick_sel = t_1;
        default: tick_sel = t_int;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [2:0] rxd_s_q, cts_s_q, tim_s_q;
  reg rxd_q, cts_q, tim_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s_q <= 3'h7;
      cts_s_q <= 3'h7;
      tim_s_q <= 3'h0;
      rxd_q <= 1'b1;
      cts_q <= 1'b1;
      tim_q <= 1'b0;
    end else begin
      rxd_s_q <= {rxd_s_q[1:0], rxd};
      cts_s_q <= {cts_s_q[1:0], clear_to_send_input_n};
      tim_s_q <= {tim_s_q[1:0], timer_clock_input};
      if (rxd_s_q[1] == rxd_s_q[2]) rxd_q <= rxd_s_q[2];
      if (cts_s_q[1] == cts_s_q[2]) cts_q <= cts_s_q[2];
      if (tim_s_q[1] == tim_s_q[2]) tim_q <= tim_s_q[2];
    end
  end
  wire cts_chg = (cts_s_q[1] == cts_s_q[2]) && (cts_s_q[2] != cts_q);
  wire tim_rise = (tim_s_q[1] == tim_s_q[2]) && tim_s_q[2] && !tim_q;

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources
  reg [15:0] div_q, pre_q;
  reg [3:0] tim16_q;
  wire t_int = (pre_q == 16'h0000);
  wire t_16 = tim_rise && (tim16_q == `USC_TICK_LAST);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 16'h0000;
      tim16_q <= 4'h0;
    end else begin
      pre_q <= t_int ? div_q : pre_q - 16'h0001;
      if (tim_rise) tim16_q <= tim16_q + 4'h1;
    end
  end
  reg [7:0] clksel_q;
  wire rx_tick = tick_sel(clksel_q[`USC_CS_RX_HI:`USC_CS_RX_LO], t_int, t_16, tim_rise);
  wire tx_tick = tick_sel(clksel_q[`USC_CS_TX_HI:`USC_CS_TX_LO], t_int, t_16, tim_rise);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes
  reg [7:0] awaddr_q, araddr_q;
  reg aw_ok_q, w_ok_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_ok_q && w_ok_q;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire wr_lane = wstrb_q[0];
  wire wr_tx = wr_go && wr_lane && (awaddr_q == `USC_OFF_TXBUF);
  wire wr_cmd = wr_go && wr_lane && (awaddr_q == `USC_OFF_CMD);
  wire rd_rx = rd_go && (s_axi_araddr == `USC_OFF_RXBUF);
  wire rd_ip = rd_go && (s_axi_araddr == `USC_OFF_IPCR);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and commands
  reg [7:0] mode1_q, imr_q;
  reg rx_en_q, tx_en_q;
  wire rx_rst = wr_cmd && wdata_q[`USC_CMD_RXRST];
  wire tx_rst = wr_cmd && wdata_q[`USC_CMD_TXRST];
  always @(posedge aclk) begin
    if (!aresetn) begin
      clksel_q <= `USC_CS_RESET;
      div_q <= `USC_DIV_RESET;
      mode1_q <= 8'h00;
      imr_q <= 8'h00;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (wr_go && wr_lane) begin
      if (awaddr_q == `USC_OFF_CLKSEL) clksel_q <= wdata_q[7:0];
      if (awaddr_q == `USC_OFF_MODE1) mode1_q <= wdata_q[7:0];
      if (awaddr_q == `USC_OFF_IMR) imr_q <= wdata_q[7:0];
      if (awaddr_q == `USC_OFF_DIV) div_q <= {wstrb_q[1] ? wdata_q[15:8] : div_q[15:8], wdata_q[7:0]};
      if (wr_cmd) begin
        if (wdata_q[`USC_CMD_RXEN]) rx_en_q <= 1'b1;
        if (wdata_q[`USC_CMD_RXDIS] || wdata_q[`USC_CMD_RXRST]) rx_en_q <= 1'b0;
        if (wdata_q[`USC_CMD_TXEN]) tx_en_q <= 1'b1;
        if (wdata_q[`USC_CMD_TXDIS] || wdata_q[`USC_CMD_TXRST]) tx_en_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  reg tx_ready_q, tx_busy_q;
  reg [7:0] tx_character_q;
  reg [8:0] tx_sh_q;
  reg [3:0] tx_cnt_q, tx_bit_q;
  wire tx_load = !tx_busy_q && !tx_ready_q && tx_en_q;
  always @(posedge aclk) begin
    if (!aresetn || tx_rst) begin
      tx_ready_q <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_character_q <= 8'h00;
      tx_sh_q <= 9'h1FF;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 4'h0;
      txd <= 1'b1;
    end else begin
      if (wr_tx && tx_ready_q) begin
        tx_character_q <= wdata_q[7:0];
        tx_ready_q <= 1'b0;
      end else if (tx_load) begin
        tx_ready_q <= 1'b1;
        tx_busy_q <= 1'b1;
        tx_sh_q <= {tx_character_q, 1'b0};
        tx_cnt_q <= 4'h0;
        tx_bit_q <= 4'h0;
      end
      if (tx_busy_q && tx_tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_cnt_q == 4'h0) begin
          txd <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        end
        if (tx_cnt_q == `USC_TICK_LAST) begin
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == `USC_BIT_STOP) tx_busy_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver and FIFO
  reg [7:0] fifo_q [0:RX_DEPTH-1];
  reg [RX_CW-1:0] wp_q, rp_q, cnt_q;
  reg rx_act_q, brk_q, dbrk_ev_q;
  reg [3:0] rx_cnt_q, rx_bit_q;
  reg [7:0] rx_sh_q;
  wire rx_ready_flag = (cnt_q != {RX_CW{1'b0}});
  wire rx_fifo_full_flag = (cnt_q == RX_DEPTH[RX_CW-1:0]);
  wire rx_done = rx_act_q && rx_tick && (rx_cnt_q == `USC_TICK_LAST) && (rx_bit_q == `USC_BIT_STOP);
  wire rx_brk = rx_done && !rxd_q && (rx_sh_q == 8'h00);
  wire push = rx_done && rxd_q && !rx_fifo_full_flag;
  wire pop = rd_rx && rx_ready_flag;
  always @(posedge aclk) begin
    if (!aresetn || rx_rst) begin
      wp_q <= {RX_CW{1'b0}};
      rp_q <= {RX_CW{1'b0}};
      cnt_q <= {RX_CW{1'b0}};
      rx_act_q <= 1'b0;
      brk_q <= 1'b0;
      dbrk_ev_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else begin
      dbrk_ev_q <= rx_brk || (brk_q && rxd_q);
      if (brk_q && rxd_q) brk_q <= 1'b0;
      if (rx_brk) brk_q <= 1'b1;
      if (push) begin
        fifo_q[wp_q] <= rx_sh_q;
        wp_q <= (wp_q == RX_DEPTH[RX_CW-1:0] - 1'b1) ? {RX_CW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) rp_q <= (rp_q == RX_DEPTH[RX_CW-1:0] - 1'b1) ? {RX_CW{1'b0}} : rp_q + 1'b1;
      cnt_q <= cnt_q + {{(RX_CW-1){1'b0}}, push} - {{(RX_CW-1){1'b0}}, pop};
      if (!rx_act_q) begin
        if (rx_en_q && !brk_q && !rxd_q && rx_tick) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= `USC_TICK_LAST - `USC_TICK_MID;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == `USC_TICK_LAST) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rxd_q) rx_act_q <= 1'b0;
          if (rx_bit_q != 4'h0 && rx_bit_q != `USC_BIT_STOP) rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
          if (rx_bit_q == `USC_BIT_STOP) rx_act_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change of state, interrupts, DMA
  reg cos_q, isr_cos_q, isr_dbrk_q;
  wire iclr = wr_go && wr_lane && (awaddr_q == `USC_OFF_ICLR);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cos_q <= 1'b0;
      isr_cos_q <= 1'b0;
      isr_dbrk_q <= 1'b0;
    end else begin
      cos_q <= cts_chg || (cos_q && !rd_ip);
      isr_cos_q <= cts_chg || (isr_cos_q && !(iclr && wdata_q[`USC_IS_COS]));
      isr_dbrk_q <= dbrk_ev_q || (isr_dbrk_q && !(iclr && wdata_q[`USC_IS_DBRK]));
    end
  end
  wire rx_sel = mode1_q[`USC_MR1_RXSEL] ? rx_fifo_full_flag : rx_ready_flag;
  wire [7:0] isr = {isr_cos_q, 4'h0, isr_dbrk_q, rx_sel, tx_ready_q};
  assign irq = |(isr & imr_q);
  assign tx_dma_req = isr[`USC_IS_TX_READY_FLAG];
  assign rx_dma_req = isr[`USC_IS_RX];
  wire [7:0] status = {2'b00, tx_en_q, rx_en_q, !tx_busy_q && tx_ready_q,
                       tx_ready_q, rx_fifo_full_flag, rx_ready_flag};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite data path
  reg [7:0] rd_d;
  always @* begin
    case (s_axi_araddr)
      `USC_OFF_STATUS: rd_d = status;
      `USC_OFF_CLKSEL: rd_d = clksel_q;
      `USC_OFF_RXBUF: rd_d = rx_ready_flag ? fifo_q[rp_q] : 8'h00;
      `USC_OFF_IPCR: rd_d = {3'b000, cos_q, 3'b000, !cts_q};
      `USC_OFF_MODE1: rd_d = mode1_q;
      `USC_OFF_ISR: rd_d = isr;
      `USC_OFF_IMR: rd_d = imr_q;
      `USC_OFF_DIV: rd_d = div_q[7:0];
      default: rd_d = 8'h00;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USC_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `USC_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? `USC_RESP_OK : `USC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `USC_RESP_OK : `USC_RESP_ERR;
        s_axi_rdata <= s_axi_araddr == `USC_OFF_DIV ? {16'h0000, div_q} : {24'h000000, rd_d};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // usc_uart

// [sim/usc_uart_chk.sv]
/* Port checker for usc_uart.
   Assumes one clock aclk and synchronous active-low aresetn. */
`timescale 1ns/1ps
module usc_uart_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire txd,
  input wire irq,
  input wire tx_dma_req,
  input wire rx_dma_req
);
  logic [3:0] quiet_q;
  ////////////////////
  // Cycles since the last bus access
  always @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid || s_axi_rvalid || (s_axi_awvalid && s_axi_awready) ||
        (s_axi_arvalid && s_axi_arready))
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_start_low;
    (!txd) [*8];
  endsequence
  ////////////////////
  AST_RST_STATE: assert property (@(posedge aclk) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && txd && tx_dma_req && !rx_dma_req && !irq) else $error("bad reset");
  AST_WR_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_taken |-> ##2 s_axi_bvalid) else $error("late bvalid");
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  AST_RD_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
  AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  AST_TX_START: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(txd) |-> s_start_low) else $error("short start bit");
  AST_TX_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(tx_dma_req) |-> quiet_q < 4'h3) else $error("tx request fell alone");
  AST_RX_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rx_dma_req) |-> quiet_q < 4'h3) else $error("rx request fell alone");
endmodule // usc_uart_chk

bind usc_uart usc_uart_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd), .irq(irq),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

// [sim/usc_line_partner.sv]
/* Remote serial device: sends 8N1 frames, collects received frames.
   Assumes BIT_CYC clocks of aclk per bit; line idles high. */
`timescale 1ns/1ps
module usc_line_partner #(
  parameter int BIT_CYC = 32
) (
  input wire aclk,
  input wire txd,
  output logic rxd,
  output logic cts_n
);
  logic [7:0] got_q [$];
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (BIT_CYC) @(posedge aclk);
  endtask
  // Start, eight data bits LSB first, stop, then idle
  task automatic send(input logic [7:0] d, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++)
      bit_out(d[i]);
    bit_out(stop);
    bit_out(1'b1);
    bit_out(1'b1);
  endtask
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask
  always begin : rx_frame
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge aclk);
    got_q.push_back(b);
  end
endmodule // usc_line_partner

// [sim/uart_buffer_clock_dma_control_bench.sv]
/* Bench for usc_uart: AXI4-Lite register tasks and a line partner.
   Assumes the divider keeps its reset value for serial timing. */
`timescale 1ns/1ps
`include "usc_consts.vh"
module uart_buffer_clock_dma_control_bench;
  localparam int BIT_CYC = (`USC_DIV_RESET + 1) * 16;
  localparam int TIM_CYC = 4;
  logic [1:0] tdiv = 2'h0;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd_v;
  logic [1:0] rs_v;
  logic [3:0] cs [3] = '{`USC_CS_INT, `USC_CS_TIM16, `USC_CS_TIM};
  logic [7:0] tx_exp [3] = '{8'h5A, 8'hA5, 8'h3C};
  wire awready, wready, bvalid, arready, rvalid, txd, irq, tx_req, rx_req, rxd, cts_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  usc_uart DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd), .txd(txd),
    .clear_to_send_input_n(cts_n), .timer_clock_input(tdiv[1]), .irq(irq), .tx_dma_req(tx_req),
    .rx_dma_req(rx_req));
  usc_line_partner #(.BIT_CYC(BIT_CYC)) u_line (.aclk(aclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  ////////////////////
  task automatic print_verdict;
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a);
    logic a_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      a_hs = arvalid && arready;
      r_hs = rvalid;
      rd_v = rdata;
      rs_v = rresp;
      @(posedge aclk);
      if (a_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, rd_v, e);
  endtask
  task automatic st(input logic [31:0] e);
    rdc("status", `USC_OFF_STATUS, e);
  endtask
  task automatic start_len(input int e);
    int len;
    len = 0;
    while (txd !== 1'b0)
      @(negedge aclk);
    while (txd === 1'b0) begin
      @(negedge aclk);
      len++;
    end
    chk("start len", 32'(len), 32'(e));
  endtask
  task automatic tx_idle;
    rd(`USC_OFF_STATUS);
    while (!rd_v[`USC_ST_TXEMP])
      rd(`USC_OFF_STATUS);
  endtask
  ////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Timer pin: one rising edge every TIM_CYC clocks
  always @(posedge aclk)
    tdiv <= tdiv + 2'h1;
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'h0C);
    rdc("clksel", `USC_OFF_CLKSEL, 32'hDD);
    @(negedge aclk);
    chk("tx_req", 32'(tx_req), 32'h1);
    chk("rx_req", 32'(rx_req), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`USC_OFF_CLKSEL, {24'h0, cs[i], cs[2 - i]}, `USC_RESP_OK);
      rdc("clksel", `USC_OFF_CLKSEL, {24'h0, cs[i], cs[2 - i]});
    end
    wr(`USC_OFF_CLKSEL, {24'h0, `USC_CS_RESET}, `USC_RESP_OK);
    wr(8'h30, 32'h1, `USC_RESP_ERR);
    rd(8'h2C);
    chk("rresp", 32'(rs_v), 32'(`USC_RESP_ERR));
    // Transmitter still disabled: second write must be ignored
    wr(`USC_OFF_TXBUF, 32'h5A, `USC_RESP_OK);
    st(32'h00);
    @(negedge aclk);
    chk("tx_req", 32'(tx_req), 32'h0);
    wr(`USC_OFF_TXBUF, 32'hC3, `USC_RESP_OK);
    wr(`USC_OFF_CMD, 32'h05, `USC_RESP_OK);
    for (int k = 1; k < 3; k++) begin
      for (int n = 0; n < 40 * BIT_CYC && tx_req !== 1'b1; n++)
        @(negedge aclk);
      wr(`USC_OFF_TXBUF, {24'h0, tx_exp[k]}, `USC_RESP_OK);
    end
    for (int n = 0; n < 40 * BIT_CYC && u_line.got_q.size() < 3; n++)
      @(negedge aclk);
    chk("tx count", 32'(u_line.got_q.size()), 32'h3);
    for (int k = 0; k < 3; k++)
      chk("tx char", 32'(u_line.got_q[k]), 32'(tx_exp[k]));
    // Transmitter on the timer pin, undivided then divided: start bit is 16 ticks
    wr(`USC_OFF_CLKSEL, {24'h0, `USC_CS_INT, `USC_CS_TIM}, `USC_RESP_OK);
    wr(`USC_OFF_TXBUF, 32'hFF, `USC_RESP_OK);
    start_len(16 * TIM_CYC);
    tx_idle();
    wr(`USC_OFF_CLKSEL, {24'h0, `USC_CS_INT, `USC_CS_TIM16}, `USC_RESP_OK);
    wr(`USC_OFF_TXBUF, 32'hFF, `USC_RESP_OK);
    start_len(256 * TIM_CYC);
    tx_idle();
    wr(`USC_OFF_CLKSEL, {24'h0, `USC_CS_RESET}, `USC_RESP_OK);
    // Receive until the fourth character is dropped
    u_line.send(8'h11, 1'b1);
    st(32'h3D);
    chk("rx_req", 32'(rx_req), 32'h1);
    u_line.send(8'h22, 1'b1);
    u_line.send(8'h33, 1'b1);
    u_line.send(8'h44, 1'b1);
    st(32'h3F);
    wr(`USC_OFF_MODE1, 32'h40, `USC_RESP_OK);
    @(negedge aclk);
    chk("rx_req", 32'(rx_req), 32'h1);
    rdc("rx char", `USC_OFF_RXBUF, 32'h11);
    @(negedge aclk);
    chk("rx_req", 32'(rx_req), 32'h0);
    rdc("rx char", `USC_OFF_RXBUF, 32'h22);
    rdc("rx char", `USC_OFF_RXBUF, 32'h33);
    st(32'h3C);
    // Interrupts beside the DMA requests
    wr(`USC_OFF_IMR, 32'h80, `USC_RESP_OK);
    u_line.set_cts(1'b0);
    for (int n = 0; n < 64 && irq !== 1'b1; n++)
      @(negedge aclk);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'h1);
    rdc("isr", `USC_OFF_ISR, 32'h81);
    rdc("ipcr", `USC_OFF_IPCR, 32'h11);
    rdc("ipcr", `USC_OFF_IPCR, 32'h01);
    wr(`USC_OFF_ICLR, 32'h80, `USC_RESP_OK);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'h0);
    wr(`USC_OFF_IMR, 32'h01, `USC_RESP_OK);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(`USC_OFF_IMR, 32'h04, `USC_RESP_OK);
    u_line.send(8'h00, 1'b0);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(`USC_OFF_ICLR, 32'h04, `USC_RESP_OK);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'h0);
    print_verdict();
  end
endmodule // uart_buffer_clock_dma_control_bench
